/* File: hw/dmaar_pkg.sv */
// Constants shared by the DMA channel address register set
package dmaar_pkg;

   localparam int DMAAR_CHANS  = 4;
   localparam int DMAAR_ADDR_W = 28;
   localparam int DMAAR_DATA_W = 16;
   localparam int DMAAR_HI_W   = 12;

   // Byte addresses of the registers, element n belongs to channel n
   localparam logic [3:0][31:0] DMAAR_SRC_LO_ADDR = {
      32'hFFFFF098, 32'hFFFFF090, 32'hFFFFF088, 32'h0FFFF680};
   localparam logic [3:0][31:0] DMAAR_SRC_HI_ADDR = {
      32'hFFFFF09C, 32'hFFFFF094, 32'hFFFFF08C, 32'hFFFFF084};
   localparam logic [3:0][31:0] DMAAR_DST_LO_ADDR = {
      32'hFFFFF0B8, 32'hFFFFF0B0, 32'hFFFFF0A8, 32'hFFFFF0A0};
   localparam logic [3:0][31:0] DMAAR_DST_HI_ADDR = {
      32'hFFFFF0BC, 32'hFFFFF0B4, 32'hFFFFF0AC, 32'hFFFFF0A4};
   localparam logic [3:0][31:0] DMAAR_CTL_ADDR = {
      32'hFFFFF0CC, 32'hFFFFF0C8, 32'hFFFFF0C4, 32'hFFFFF0C0};
   localparam logic [31:0] DMAAR_STATUS_ADDR = 32'hFFFFF0E0;

   // Field positions
   localparam int DMAAR_TRANSFER_TYPE_BIT_BIT        = 0;
   localparam int DMAAR_STAT_SPEND_LSB  = 0;
   localparam int DMAAR_STAT_DPEND_LSB  = 4;
   localparam int DMAAR_STAT_BUSY_LSB   = 8;
   localparam int DMAAR_STAT_FLYBY_LSB  = 12;

   // Reset values
   localparam logic [27:0] DMAAR_ADDR_RST  = 28'h0000000;
   localparam logic [15:0] DMAAR_RDATA_RST = 16'h0000;
   localparam logic [3:0]  DMAAR_FLYBY_RST = 4'h0;

endpackage : dmaar_pkg

/* File: hw/dmaar_stage.sv */
// Two-stage address buffer: staged value written by software, working value
module dmaar_stage (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic [15:0] wdata,
   input  wire logic        busy,
   input  wire logic        done,
   output logic      [27:0] staged,
   output logic      [27:0] working,
   output logic             pending
);

   typedef struct packed {
      logic [27:0] staged_r;
      logic [27:0] working_r;
      logic        pend_r;
   } dmaar_stage_t;

   dmaar_stage_t cur_r;
   dmaar_stage_t cur_nxt;

   always_comb begin
      cur_nxt = cur_r;
      if (wr_lo) begin
         cur_nxt.staged_r[15:0] = wdata;
      end
      if (wr_hi) begin
         cur_nxt.staged_r[27:16] = wdata[11:0];
      end
      if (!busy) begin
         // Idle channel: a write takes effect at once
         cur_nxt.working_r = cur_nxt.staged_r;
         cur_nxt.pend_r    = 1'b0;
      end else if (done) begin
         // Completion promotes the next address, a same-cycle write included
         cur_nxt.working_r = cur_nxt.staged_r;
         cur_nxt.pend_r    = 1'b0;
      end else if (wr_lo || wr_hi) begin
         cur_nxt.pend_r = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_r.staged_r  <= dmaar_pkg::DMAAR_ADDR_RST;
         cur_r.working_r <= dmaar_pkg::DMAAR_ADDR_RST;
         cur_r.pend_r    <= 1'b0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign staged  = cur_r.staged_r;
   assign working = cur_r.working_r;
   assign pending = cur_r.pend_r;

   default clocking stg_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   hold_while_busy_a: assert property (
      busy && !done |=> working == $past(working))
      else $error("working address changed during transfer");

   stage_during_busy_a: assert property (
      busy && !done && wr_lo |=> staged[15:0] == $past(wdata) && pending)
      else $error("write during transfer not staged");

   promote_done_a: assert property (
      busy && done && !wr_lo && !wr_hi |=> working == $past(staged)
         && !pending)
      else $error("staged address not promoted on completion");

   promote_c: cover property (busy && wr_lo ##[1:20] busy && done);

endmodule : dmaar_stage

/* File: hw/dmaar_top.sv */
// Four-channel DMA source and destination address register set

// Contract
// - Address registers are read and written only as whole 16-bit units.
// - Each of channels 0 to 3 holds a 28-bit destination address in two halves.
// - Destination storage is two-stage so the next address can be set mid-transfer.
// - In flyby mode the destination registers of that channel are disregarded.
// - The low source register holds source address bits 15 to 0.
// - In flyby mode the memory address comes from the source registers.
module dmaar_top (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [31:0]       reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [15:0]       reg_rdata,
   input  wire logic [3:0]        xfer_busy,
   input  wire logic [3:0]        xfer_done,
   output logic      [3:0][27:0]  chan_src_addr,
   output logic      [3:0][27:0]  chan_dst_addr,
   output logic      [3:0]        chan_dst_valid,
   output logic      [3:0]        chan_flyby,
   output logic      [3:0][27:0]  chan_mem_addr
);

   typedef struct packed {
      logic [15:0] rdata_r;
      logic [3:0]  flyby_r;
   } dmaar_top_t;

   dmaar_top_t cur_r;
   dmaar_top_t cur_nxt;

   logic [3:0]       src_lo_wr;
   logic [3:0]       src_hi_wr;
   logic [3:0]       dst_lo_wr;
   logic [3:0]       dst_hi_wr;
   logic [3:0]       ctl_wr;
   logic [3:0]       src_pend;
   logic [3:0]       dst_pend;
   logic [3:0][27:0] src_stg;
   logic [3:0][27:0] src_wrk;
   logic [3:0][27:0] dst_stg;
   logic [3:0][27:0] dst_wrk;
   logic [15:0]      rd_sel;

   genvar n;
   generate
      for (n = 0; n < dmaar_pkg::DMAAR_CHANS; n++) begin : g_chan
         // Full 16-bit writes only: no byte lanes exist on this port
         assign src_lo_wr[n] = reg_wr &&
            (reg_addr == dmaar_pkg::DMAAR_SRC_LO_ADDR[n]);
         assign src_hi_wr[n] = reg_wr &&
            (reg_addr == dmaar_pkg::DMAAR_SRC_HI_ADDR[n]);
         assign dst_lo_wr[n] = reg_wr &&
            (reg_addr == dmaar_pkg::DMAAR_DST_LO_ADDR[n]);
         assign dst_hi_wr[n] = reg_wr &&
            (reg_addr == dmaar_pkg::DMAAR_DST_HI_ADDR[n]);
         assign ctl_wr[n]    = reg_wr &&
            (reg_addr == dmaar_pkg::DMAAR_CTL_ADDR[n]);

         dmaar_stage u_src (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .wr_lo   (src_lo_wr[n]),
            .wr_hi   (src_hi_wr[n]),
            .wdata   (reg_wdata),
            .busy    (xfer_busy[n]),
            .done    (xfer_done[n]),
            .staged  (src_stg[n]),
            .working (src_wrk[n]),
            .pending (src_pend[n])
         );

         dmaar_stage u_dst (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .wr_lo   (dst_lo_wr[n]),
            .wr_hi   (dst_hi_wr[n]),
            .wdata   (reg_wdata),
            .busy    (xfer_busy[n]),
            .done    (xfer_done[n]),
            .staged  (dst_stg[n]),
            .working (dst_wrk[n]),
            .pending (dst_pend[n])
         );

         assign chan_src_addr[n]  = src_wrk[n];
         // Flyby masks the destination so the engine cannot use it
         assign chan_dst_addr[n]  = cur_r.flyby_r[n] ?
            dmaar_pkg::DMAAR_ADDR_RST : dst_wrk[n];
         assign chan_dst_valid[n] = !cur_r.flyby_r[n];
         assign chan_mem_addr[n]  = cur_r.flyby_r[n] ?
            src_wrk[n] : dst_wrk[n];
      end
   endgenerate

   // Read mux; software sees the staged value it last wrote
   always_comb begin
      rd_sel = dmaar_pkg::DMAAR_RDATA_RST;
      for (int i = 0; i < dmaar_pkg::DMAAR_CHANS; i++) begin
         if (reg_addr == dmaar_pkg::DMAAR_SRC_LO_ADDR[i]) begin
            rd_sel = src_stg[i][15:0];
         end
         if (reg_addr == dmaar_pkg::DMAAR_SRC_HI_ADDR[i]) begin
            rd_sel = {4'h0, src_stg[i][27:16]};
         end
         if (reg_addr == dmaar_pkg::DMAAR_DST_LO_ADDR[i]) begin
            rd_sel = dst_stg[i][15:0];
         end
         if (reg_addr == dmaar_pkg::DMAAR_DST_HI_ADDR[i]) begin
            rd_sel = {4'h0, dst_stg[i][27:16]};
         end
         if (reg_addr == dmaar_pkg::DMAAR_CTL_ADDR[i]) begin
            rd_sel[dmaar_pkg::DMAAR_TRANSFER_TYPE_BIT_BIT] = cur_r.flyby_r[i];
         end
      end
      if (reg_addr == dmaar_pkg::DMAAR_STATUS_ADDR) begin
         rd_sel[dmaar_pkg::DMAAR_STAT_SPEND_LSB +: 4] = src_pend;
         rd_sel[dmaar_pkg::DMAAR_STAT_DPEND_LSB +: 4] = dst_pend;
         rd_sel[dmaar_pkg::DMAAR_STAT_BUSY_LSB  +: 4] = xfer_busy;
         rd_sel[dmaar_pkg::DMAAR_STAT_FLYBY_LSB +: 4] = cur_r.flyby_r;
      end
   end

   always_comb begin
      cur_nxt = cur_r;
      // Read data stand for exactly one cycle, zero otherwise
      cur_nxt.rdata_r = reg_rd ? rd_sel :
         dmaar_pkg::DMAAR_RDATA_RST;
      for (int i = 0; i < dmaar_pkg::DMAAR_CHANS; i++) begin
         if (ctl_wr[i]) begin
            cur_nxt.flyby_r[i] = reg_wdata[dmaar_pkg::DMAAR_TRANSFER_TYPE_BIT_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_r.rdata_r <= dmaar_pkg::DMAAR_RDATA_RST;
         cur_r.flyby_r <= dmaar_pkg::DMAAR_FLYBY_RST;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign reg_rdata  = cur_r.rdata_r;
   assign chan_flyby = cur_r.flyby_r;

   default clocking top_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   rdata_one_cycle_a: assert property (
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data present without a read");

   status_read_a: assert property (
      reg_rd && reg_addr == dmaar_pkg::DMAAR_STATUS_ADDR
      |=> reg_rdata[11:8] == $past(xfer_busy))
      else $error("status busy field wrong");

   status_pend_a: assert property (
      reg_rd && reg_addr == dmaar_pkg::DMAAR_STATUS_ADDR
      |=> reg_rdata[7:4] == $past(dst_pend)
         && reg_rdata[3:0] == $past(src_pend))
      else $error("status pending fields wrong");

   status_flyby_a: assert property (
      reg_rd && reg_addr == dmaar_pkg::DMAAR_STATUS_ADDR
      |=> reg_rdata[15:12] == $past(chan_flyby))
      else $error("status flyby field wrong");

   generate
      for (n = 0; n < dmaar_pkg::DMAAR_CHANS; n++) begin : g_chk
         src_lo_back_a: assert property (
            reg_wr && reg_addr == dmaar_pkg::DMAAR_SRC_LO_ADDR[n]
            ##1 reg_rd && reg_addr == dmaar_pkg::DMAAR_SRC_LO_ADDR[n]
            |=> reg_rdata == $past(reg_wdata, 2))
            else $error("source low read back wrong");

         dst_hi_split_a: assert property (
            dst_hi_wr[n] && !xfer_busy[n]
            |=> dst_wrk[n][27:16] == $past(reg_wdata[11:0])
               && $stable(dst_wrk[n][15:0]))
            else $error("destination high half not stored");

         dst_busy_hold_a: assert property (
            dst_lo_wr[n] && xfer_busy[n] && !xfer_done[n]
            |=> dst_stg[n][15:0] == $past(reg_wdata)
               && dst_wrk[n] == $past(dst_wrk[n]))
            else $error("destination write disturbed active address");

         flyby_ignore_a: assert property (
            chan_flyby[n] |-> chan_dst_addr[n] == 28'h0000000
               && !chan_dst_valid[n])
            else $error("destination used in flyby mode");

         flyby_mem_a: assert property (
            chan_flyby[n] |-> chan_mem_addr[n] == chan_src_addr[n])
            else $error("flyby memory address not from source");

         two_cycle_mem_a: assert property (
            !chan_flyby[n] |-> chan_mem_addr[n] == chan_dst_addr[n])
            else $error("two-cycle memory address not from destination");

         promote_a: assert property (
            xfer_busy[n] && xfer_done[n] && !dst_lo_wr[n]
               && !dst_hi_wr[n]
            |=> dst_wrk[n] == $past(dst_stg[n]))
            else $error("destination not promoted at completion");

         src_lo_read_a: assert property (
            reg_rd && reg_addr == dmaar_pkg::DMAAR_SRC_LO_ADDR[n]
            |=> reg_rdata == $past(src_stg[n][15:0]))
            else $error("source low read data wrong");

         src_hi_read_a: assert property (
            reg_rd && reg_addr == dmaar_pkg::DMAAR_SRC_HI_ADDR[n]
            |=> reg_rdata == {4'h0, $past(src_stg[n][27:16])})
            else $error("source high read data wrong");

         dst_lo_read_a: assert property (
            reg_rd && reg_addr == dmaar_pkg::DMAAR_DST_LO_ADDR[n]
            |=> reg_rdata == $past(dst_stg[n][15:0]))
            else $error("destination low read data wrong");

         dst_hi_read_a: assert property (
            reg_rd && reg_addr == dmaar_pkg::DMAAR_DST_HI_ADDR[n]
            |=> reg_rdata == {4'h0, $past(dst_stg[n][27:16])})
            else $error("destination high read data wrong");

         ctl_read_a: assert property (
            reg_rd && reg_addr == dmaar_pkg::DMAAR_CTL_ADDR[n]
            |=> reg_rdata == {15'h0000, $past(chan_flyby[n])})
            else $error("control read data wrong");

         flyby_set_a: assert property (
            ctl_wr[n] |=> chan_flyby[n]
               == $past(reg_wdata[dmaar_pkg::DMAAR_TRANSFER_TYPE_BIT_BIT]))
            else $error("transfer type not taken from write");

         flyby_hold_a: assert property (
            !ctl_wr[n] |=> $stable(chan_flyby[n]))
            else $error("transfer type changed without write");

         src_idle_wr_a: assert property (
            src_lo_wr[n] && !xfer_busy[n]
            |=> src_wrk[n][15:0] == $past(reg_wdata))
            else $error("idle source low write not applied");

         src_hi_mask_a: assert property (
            src_hi_wr[n] && !xfer_busy[n]
            |=> src_wrk[n][27:16] == $past(reg_wdata[11:0]))
            else $error("idle source high write not applied");

         dst_idle_wr_a: assert property (
            dst_lo_wr[n] && !xfer_busy[n]
            |=> dst_wrk[n][15:0] == $past(reg_wdata))
            else $error("idle destination write not applied");

         src_busy_hold_a: assert property (
            src_lo_wr[n] && xfer_busy[n] && !xfer_done[n]
            |=> src_pend[n] && src_wrk[n] == $past(src_wrk[n]))
            else $error("source write disturbed active address");

         dst_pend_set_a: assert property (
            dst_lo_wr[n] && xfer_busy[n] && !xfer_done[n]
            |=> dst_pend[n])
            else $error("destination pending not set");

         pend_clear_a: assert property (
            xfer_busy[n] && xfer_done[n]
            |=> !dst_pend[n] && !src_pend[n])
            else $error("pending not cleared at completion");
      end
   endgenerate

   flyby_c: cover property (
      ctl_wr[0] && reg_wdata[0] ##1 chan_flyby[0]);

   next_addr_c: cover property (
      xfer_busy[1] && dst_lo_wr[1] ##[1:30] xfer_done[1]);

   read_back_c: cover property (
      reg_rd && reg_addr == dmaar_pkg::DMAAR_SRC_LO_ADDR[2]
      ##1 reg_rdata != 16'h0000);

   src_stage_c: cover property (
      xfer_busy[2] && src_lo_wr[2] ##1 src_pend[2]);

endmodule : dmaar_top

/* File: dv/tb_top.sv */
// Self-checking testbench for the DMA channel address register set
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic              ref_clk;
   logic              rst_n;
   logic [31:0]       reg_addr;
   logic [15:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [15:0]       reg_rdata;
   logic [3:0]        xfer_busy;
   logic [3:0]        xfer_done;
   logic [3:0][27:0]  chan_src_addr;
   logic [3:0][27:0]  chan_dst_addr;
   logic [3:0]        chan_dst_valid;
   logic [3:0]        chan_flyby;
   logic [3:0][27:0]  chan_mem_addr;
   int                err_count;
   int                cmp_count;
   logic [27:0]       src_m;
   logic [27:0]       dst_m;
   logic [27:0]       dst_old;
   logic [15:0]       v;
   logic [11:0]       h;

   dmaar_top u_dut (
      .ref_clk        (ref_clk),
      .rst_n          (rst_n),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata      (reg_rdata),
      .xfer_busy      (xfer_busy),
      .xfer_done      (xfer_done),
      .chan_src_addr  (chan_src_addr),
      .chan_dst_addr  (chan_dst_addr),
      .chan_dst_valid (chan_dst_valid),
      .chan_flyby     (chan_flyby),
      .chan_mem_addr  (chan_mem_addr)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [27:0] mem_exp(input logic f,
                                           input logic [27:0] s,
                                           input logic [27:0] d);
      return f ? s : d;
   endfunction : mem_exp

   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t mismatch got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge ref_clk);
      #1 chk(reg_rdata, 16'h0000);
   endtask : rd

   task automatic wr_rd(input logic [31:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, d);
   endtask : wr_rd

   initial begin
      #200us;
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      end_sim();
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = 32'h00000000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      xfer_busy = 4'h0;
      xfer_done = 4'h0;
      err_count = 0;
      cmp_count = 0;
      void'($urandom(32'h42C8));
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1 chk(chan_dst_valid, 4'hF);
      chk(chan_flyby, 4'h0);
      for (int ch = 0; ch < 4; ch++) begin
         // Corner values on channel 0 source and channel 1 destination low, random elsewhere
         v = (ch == 0) ? 16'hFFFF : 16'($urandom);
         h = (ch == 0) ? 12'hFFF : 12'($urandom);
         src_m = {h, v};
         wr_rd(dmaar_pkg::DMAAR_SRC_LO_ADDR[ch], v);
         wr(dmaar_pkg::DMAAR_SRC_HI_ADDR[ch], {4'hF, h});
         rd(dmaar_pkg::DMAAR_SRC_LO_ADDR[ch], v);
         rd(dmaar_pkg::DMAAR_SRC_HI_ADDR[ch], {4'h0, h});
         v = (ch == 1) ? 16'h0000 : 16'($urandom);
         h = 12'($urandom);
         dst_m = {h, v};
         wr(dmaar_pkg::DMAAR_DST_LO_ADDR[ch], v);
         wr(dmaar_pkg::DMAAR_DST_HI_ADDR[ch], {4'hA, h});
         rd(dmaar_pkg::DMAAR_DST_LO_ADDR[ch], v);
         rd(dmaar_pkg::DMAAR_DST_HI_ADDR[ch], {4'h0, h});
         chk(chan_src_addr[ch], src_m);
         chk(chan_dst_addr[ch], dst_m);
         chk(chan_mem_addr[ch], mem_exp(1'b0, src_m, dst_m));
         // Next destination staged while the channel is busy
         @(posedge ref_clk);
         xfer_busy[ch] <= 1'b1;
         dst_old = dst_m;
         v = 16'($urandom);
         dst_m[15:0] = v;
         wr(dmaar_pkg::DMAAR_DST_LO_ADDR[ch], v);
         wr(dmaar_pkg::DMAAR_SRC_LO_ADDR[ch], ~v);
         chk(chan_dst_addr[ch], dst_old);
         chk(chan_src_addr[ch], src_m);
         src_m[15:0] = ~v;
         rd(dmaar_pkg::DMAAR_STATUS_ADDR,
            16'(16'h0111 << ch));
         chk(chan_dst_addr[ch], dst_old);
         @(posedge ref_clk);
         xfer_done[ch] <= 1'b1;
         @(posedge ref_clk);
         xfer_done[ch] <= 1'b0;
         xfer_busy[ch] <= 1'b0;
         #1 chk(chan_dst_addr[ch], dst_m);
         chk(chan_mem_addr[ch], dst_m);
         chk(chan_src_addr[ch], src_m);
         // Flyby: destination disregarded, source addresses memory
         wr(dmaar_pkg::DMAAR_CTL_ADDR[ch], 16'h0001);
         chk(chan_flyby[ch], 1'b1);
         chk(chan_dst_valid[ch], 1'b0);
         chk(chan_dst_addr[ch], 28'h0000000);
         chk(chan_mem_addr[ch], mem_exp(1'b1, src_m, dst_m));
         rd(dmaar_pkg::DMAAR_CTL_ADDR[ch], 16'h0001);
         rd(dmaar_pkg::DMAAR_STATUS_ADDR, 16'(16'h1000 << ch));
         wr(dmaar_pkg::DMAAR_CTL_ADDR[ch], 16'h0000);
         chk(chan_dst_valid[ch], 1'b1);
         chk(chan_mem_addr[ch], mem_exp(1'b0, src_m, dst_m));
      end
      // Unmapped place: write ignored, read gives zero
      wr(32'hFFFFF0E4, 16'h5A5A);
      rd(32'hFFFFF0E4, 16'h0000);
      rd(dmaar_pkg::DMAAR_STATUS_ADDR, 16'h0000);
      end_sim();
   end

endmodule : tb_top
